// [verilog/decay_blank_ctrl.sv]
// PWM chopping decay and blanking controller for one H-bridge
//
// Operation
// RQ1 - Trip reference is sine level times torque; code 31 full torque 500 mV
// RQ2 - On trip the bridge stops driving and recirculates until off period ends
// RQ3 - Fast decay reverses the bridge and turns it off near zero current
// RQ4 - Slow decay turns on both low-side transistors
// RQ5 - Mixed decay runs fast first, then slow for the rest of off period
// RQ6 - Both decay select pins are three-state, nine configurations
// RQ7 - Falling current decay table over the nine decay select pairs
// RQ8 - Rising current is slow except Z0, ZZ and Z1 pairs
// RQ9 - Adaptive decay needs adaptive pin high and both decay pins high
// RQ10 - Adaptive pin is sampled only on sleep exit
// RQ11 - Adaptive: drive longer than blanking gives slow decay
// RQ12 - Adaptive: first overshoot one blanking fast, second two blankings
// RQ13 - Adaptive: third and later overshoots give fast for quarter off time
// RQ14 - Adaptive: short of regulation, slow decay until current exceeds it
// RQ15 - Adaptive: on step change restart at one blanking and escalate
// RQ16 - Comparator ignored during blanking, which is minimum drive time
// RQ17 - Blanking interval chosen from sine code group and torque setting
// RQ18 - Off period from tri-level pin: low 20, floating 10, high 30 us
// RQ19 - Torque pins decode to a 4-bit linear level, 0 to 8, of 12.5 percent steps
// RQ20 - Both torque pins high forces the bridge outputs off
// RQ21 - Each tri-level pin becomes one two-bit internal code
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module decay_blank_ctrl (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [decay_pkg::CODE_W-1:0]   sine_code,
    input  wire logic                           current_rising,
    input  wire logic                           phase_pos,
    input  wire logic                           sleep_request_n,
    input  wire logic                           adaptive_decay_pin,
    input  wire logic [1:0]                     decay_sel_hi,
    input  wire logic [1:0]                     decay_sel_lo,
    input  wire logic [1:0]                     off_time_select,
    input  wire logic [1:0]                     torque_sel_hi,
    input  wire logic [1:0]                     torque_sel_lo,
    input  wire logic                           current_sense_node,
    input  wire logic                           zero_cross,
    output logic                                gate_hs1,
    output logic                                gate_ls1,
    output logic                                gate_hs2,
    output logic                                gate_ls2,
    output logic                                sense_masked,
    output logic [decay_pkg::MV_W-1:0]          trip_ref_mv
);
    import decay_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    assign raw_in = {sleep_request_n, adaptive_decay_pin, decay_sel_hi,
                     decay_sel_lo, off_time_select, torque_sel_hi,
                     torque_sel_lo, current_sense_node, zero_cross};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= raw_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    wire       awake_s = sync_b[13];
    wire       adaptive_decay_pin_s  = sync_b[12];
    wire       trip_s  = sync_b[1];
    wire       zero_s  = sync_b[0];

    ////////////////////////////////////////////////////////////////////////
    // Tri-level decode, pad bit 1 = pulled high, bit 0 = pulled low
    function automatic logic [1:0] tri_code(input logic [1:0] det);
        tri_code = det[1] ? TRI_HI : (det[0] ? TRI_LO : TRI_Z); // RQ21
    endfunction

    function automatic logic [3:0] pair_idx(input logic [1:0] hi,
                                            input logic [1:0] lo);
        pair_idx = 4'(tri_code(hi)) * 4'h3 + 4'(tri_code(lo)); // RQ6
    endfunction

    wire [3:0] dec_idx = pair_idx(sync_b[11:10], sync_b[9:8]);    // RQ6
    wire [3:0] trq_idx = pair_idx(sync_b[5:4], sync_b[3:2]);
    wire [1:0] off_sel = tri_code(sync_b[7:6]);
    wire [3:0] trq_lvl = TORQUE_FULL - trq_idx;                    // RQ19

    wire [CNT_W-1:0] off_len =
        (off_sel == TRI_HI) ? OFF_HI_CYC :
        (off_sel == TRI_Z)  ? OFF_Z_CYC  : OFF_LO_CYC;             // RQ18

    // Blanking from sine code group and torque index
    wire [1:0] grp = sine_code[4] ? 2'h3 : sine_code[3] ? 2'h2 :
                     sine_code[2] ? 2'h1 : 2'h0;
    logic [CNT_W-1:0] blank_len;
    always_comb begin
        blank_len = BLANK_090_CYC;                                 // RQ17
        case (grp)
            2'h3: blank_len = (trq_idx < 4'h2) ? BLANK_180_CYC :
                              (trq_idx < 4'h5) ? BLANK_150_CYC :
                              (trq_idx < 4'h7) ? BLANK_120_CYC :
                              BLANK_090_CYC;
            2'h2: blank_len = (trq_idx < 4'h3) ? BLANK_150_CYC :
                              (trq_idx < 4'h6) ? BLANK_120_CYC :
                              BLANK_090_CYC;
            2'h1: blank_len = (trq_idx < 4'h3) ? BLANK_120_CYC :
                              BLANK_090_CYC;
            default: blank_len = BLANK_090_CYC;
        endcase
    end

    // Fixed decay kind from the pin pair and current direction
    logic [2:0] kind;
    always_comb begin
        kind = DK_SLOW;
        case (dec_idx)
            4'h1: kind = current_rising ? DK_SLOW : DK_P25;        // RQ7
            4'h2: kind = current_rising ? DK_SLOW : DK_BL1;        // RQ7
            4'h3: kind = DK_BL1;                                   // RQ8
            4'h4: kind = DK_P50;                                   // RQ8
            4'h5: kind = DK_P25;                                   // RQ8
            4'h6: kind = current_rising ? DK_SLOW : DK_P50;        // RQ7
            4'h7: kind = current_rising ? DK_SLOW : DK_P12;        // RQ7
            4'h8: kind = current_rising ? DK_SLOW : DK_FULL;       // RQ7
            default: kind = DK_SLOW;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Trip reference
    logic [MV_W-1:0] base_mv;
    sine_trip_rom u_rom (
        .pclk    (pclk),
        .presetn (presetn),
        .code    (sine_code),
        .mv      (base_mv)
    );
    wire [12:0] trip_prod = 13'(base_mv) * 13'(trq_lvl) + 13'h4;   // RQ1

    ////////////////////////////////////////////////////////////////////////
    // Chopping state machine
    chop_state_e      state;
    chop_state_e      next_state;
    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] fast_len;
    logic [1:0]       os_cnt;
    logic             adaptive_lat;
    logic             awake_prev;
    logic [CODE_W-1:0] prev_code;
    logic [31:0]      ctrl;

    wire adaptive_on = adaptive_lat && dec_idx == 4'h8;            // RQ9
    wire go          = awake_s && ctrl[CTRL_EN_BIT] && trq_lvl != 4'h0;
    wire blank_end   = elapsed + 10'h1 >= blank_len;
    wire in_decay    = state == ST_FAST || state == ST_SLOW ||
                       state == ST_COAST;
    wire off_end     = elapsed + 10'h1 >= off_len;
    wire over_shoot  = state == ST_BLANK && blank_end && trip_s;
    wire trip_now    = over_shoot || (state == ST_DRIVE && trip_s);
    wire [1:0] next_os = !over_shoot ? 2'h0 :
                         (os_cnt == 2'h3) ? 2'h3 : os_cnt + 2'h1;

    logic [CNT_W-1:0] next_fast;
    always_comb begin
        next_fast = '0;
        if (adaptive_on) begin
            case (next_os)
                2'h1: next_fast = blank_len;                       // RQ12
                2'h2: next_fast = CNT_W'(blank_len << 1);          // RQ12
                2'h3: next_fast = off_len >> 2;                    // RQ13
                default: next_fast = '0;                           // RQ11
            endcase
        end else begin
            case (kind)
                DK_BL1:  next_fast = blank_len;                    // RQ5
                DK_P25:  next_fast = off_len >> 2;
                DK_P50:  next_fast = off_len >> 1;
                DK_P12:  next_fast = off_len >> 3;
                DK_FULL: next_fast = off_len;
                default: next_fast = '0;
            endcase
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_SLEEP: next_state = ST_BLANK;
            ST_BLANK: begin
                if (blank_end) begin                               // RQ16
                    next_state = ST_DRIVE;
                end
            end
            ST_DRIVE: next_state = ST_DRIVE;
            ST_FAST, ST_COAST: begin
                if (off_end) begin
                    next_state = ST_BLANK;
                end else if (elapsed + 10'h1 >= fast_len) begin
                    next_state = ST_SLOW;                          // RQ5
                end else if (zero_s) begin
                    next_state = ST_COAST;                         // RQ3
                end
            end
            ST_SLOW: begin
                if (off_end) begin
                    next_state = ST_BLANK;                         // RQ18
                end
            end
            default: next_state = ST_SLEEP;
        endcase
        if (trip_now) begin
            next_state = (next_fast != '0) ? ST_FAST : ST_SLOW;    // RQ2
        end
        if (!go) begin
            next_state = ST_SLEEP;                                 // RQ20
        end
    end

    wire restart = (next_state == ST_BLANK && state != ST_BLANK) || trip_now;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= ST_SLEEP;
            elapsed  <= '0;
            fast_len <= '0;
            os_cnt   <= 2'h0;
        end else begin
            state   <= next_state;
            elapsed <= restart ? '0 : elapsed + 10'h1;
            if (trip_now) begin
                fast_len <= next_fast;
                os_cnt   <= next_os;                               // RQ14
            end else if (sine_code != prev_code) begin
                os_cnt   <= 2'h0;                                  // RQ15
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            awake_prev   <= 1'b0;
            adaptive_lat <= 1'b0;
            prev_code    <= '0;
        end else begin
            awake_prev <= awake_s;
            prev_code  <= sine_code;
            if (awake_s && !awake_prev) begin
                adaptive_lat <= adaptive_decay_pin_s;                            // RQ10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate outputs follow the state entered
    wire drv   = next_state == ST_BLANK || next_state == ST_DRIVE;
    wire fst   = next_state == ST_FAST;                            // RQ3
    wire slw   = next_state == ST_SLOW;                            // RQ4
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_hs1     <= 1'b0;
            gate_ls1     <= 1'b0;
            gate_hs2     <= 1'b0;
            gate_ls2     <= 1'b0;
            sense_masked <= 1'b1;
            trip_ref_mv  <= '0;
        end else begin
            gate_hs1     <= (drv && phase_pos) || (fst && !phase_pos);
            gate_ls2     <= (drv && phase_pos) || (fst && !phase_pos) || slw;
            gate_hs2     <= (drv && !phase_pos) || (fst && phase_pos);
            gate_ls1     <= (drv && !phase_pos) || (fst && phase_pos) || slw;
            sense_masked <= next_state != ST_DRIVE;                // RQ16
            trip_ref_mv  <= trip_prod[11:3];                       // RQ1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave, no wait states
    wire setup  = psel && !penable;
    wire hit_c  = paddr == ADDR_CTRL;
    wire hit_s  = paddr == ADDR_STATUS;
    wire [31:0] status_w = (32'(state) << ST_STATE_LSB) |
                           (32'(os_cnt) << ST_OS_LSB) |
                           (32'(adaptive_on) << ST_ADAPT_BIT) |
                           (32'(trip_ref_mv) << ST_TRIP_LSB);
    wire [31:0] rd_mux = hit_c ? ctrl : hit_s ? status_w : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl    <= CTRL_RESET;
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit_c && !hit_s;
            if (setup) begin
                prdata <= pwrite ? 32'h0 : rd_mux;
            end
            if (psel && penable && pready && pwrite && hit_c) begin
                ctrl <= 32'(pwdata[CTRL_EN_BIT]) << CTRL_EN_BIT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_TRIP_FULL: assert property ( // RQ1
        $past(sine_code, 2) == 5'h1f && $past(trq_lvl) == TORQUE_FULL
        |-> trip_ref_mv == TRIP_FULL_MV)
        else $error("trip level not full scale");
    AST_TRIP_ENDS_DRIVE: assert property ( // RQ2
        state == ST_DRIVE && trip_s && go
        |=> (state == ST_FAST || state == ST_SLOW) && !gate_hs1 && !gate_hs2
            || gate_hs1 != gate_hs2 && state == ST_FAST)
        else $error("drive continued after trip");
    AST_FAST_GATES: assert property ( // RQ3
        state == ST_FAST |-> gate_hs1 == !phase_pos && gate_hs2 == phase_pos
        || $changed(phase_pos))
        else $error("fast decay gates wrong");
    AST_SLOW_GATES: assert property ( // RQ4
        state == ST_SLOW |-> gate_ls1 && gate_ls2 && !gate_hs1 && !gate_hs2)
        else $error("slow decay gates wrong");
    AST_MIXED_SWITCH: assert property ( // RQ5
        state == ST_FAST && go && !trip_now && !off_end
        && elapsed + 10'h1 == fast_len |=> state == ST_SLOW)
        else $error("mixed decay did not switch to slow");
    AST_BLANK_HOLD: assert property ( // RQ16
        state == ST_BLANK && go && !blank_end |=> state == ST_BLANK)
        else $error("comparator seen during blanking");
    AST_OFF_END: assert property ( // RQ18
        in_decay && go && off_end |=> state == ST_BLANK ##1 sense_masked)
        else $error("off period not ended on time");
    AST_TORQUE_OFF: assert property ( // RQ20
        trq_lvl == 4'h0 |=> !gate_hs1 && !gate_hs2 && !gate_ls1 && !gate_ls2)
        else $error("outputs on at zero torque");
    AST_ADAPT_SLOW: assert property ( // RQ11
        adaptive_on && state == ST_DRIVE && trip_s && go |=> state == ST_SLOW)
        else $error("adaptive long drive not slow");
    AST_ESCALATE: assert property ( // RQ13
        adaptive_on && over_shoot && os_cnt >= 2'h2 && go
        |=> fast_len == $past(off_len) >> 2)
        else $error("third overshoot not quarter off time");

    COV_MIXED: cover property (state == ST_FAST ##1 state == ST_SLOW);
    COV_COAST: cover property (state == ST_FAST ##1 state == ST_COAST);
    COV_ADAPT3: cover property (adaptive_on && os_cnt == 2'h3);
endmodule // decay_blank_ctrl

// [verilog/decay_pkg.sv]
// Constants, encodings and register map for the chopping decay controller
package decay_pkg;
    localparam int CLK_MHZ = 20;
    localparam int CODE_W  = 5;
    localparam int MV_W    = 9;
    localparam int CNT_W   = 10;
    localparam int NSYNC   = 14;

    // Tri-level internal codes
    localparam logic [1:0] TRI_LO = 2'h0;
    localparam logic [1:0] TRI_Z  = 2'h1;
    localparam logic [1:0] TRI_HI = 2'h2;

    // Off period, microseconds, and cycle counts
    localparam int OFF_LO_US = 20;
    localparam int OFF_Z_US  = 10;
    localparam int OFF_HI_US = 30;
    localparam logic [CNT_W-1:0] OFF_LO_CYC = CNT_W'(OFF_LO_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] OFF_Z_CYC  = CNT_W'(OFF_Z_US * CLK_MHZ);
    localparam logic [CNT_W-1:0] OFF_HI_CYC = CNT_W'(OFF_HI_US * CLK_MHZ);

    // Blanking interval, nanoseconds, and least cycle counts
    localparam int BLANK_180_NS = 1800;
    localparam int BLANK_150_NS = 1500;
    localparam int BLANK_120_NS = 1200;
    localparam int BLANK_090_NS = 900;
    localparam logic [CNT_W-1:0] BLANK_180_CYC =
        CNT_W'((BLANK_180_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] BLANK_150_CYC =
        CNT_W'((BLANK_150_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] BLANK_120_CYC =
        CNT_W'((BLANK_120_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] BLANK_090_CYC =
        CNT_W'((BLANK_090_NS * CLK_MHZ + 999) / 1000);

    // Trip reference
    localparam logic [MV_W-1:0] TRIP_FULL_MV = 9'h1f4;
    localparam logic [3:0]      TORQUE_FULL  = 4'h8;

    // APB register map
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam int          CTRL_EN_BIT   = 0;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
    localparam int          ST_STATE_LSB  = 0;
    localparam int          ST_OS_LSB     = 3;
    localparam int          ST_ADAPT_BIT  = 5;
    localparam int          ST_TRIP_LSB   = 16;

    typedef enum logic [2:0] {
        ST_SLEEP = 3'h0,
        ST_BLANK = 3'h1,
        ST_DRIVE = 3'h3,
        ST_FAST  = 3'h2,
        ST_SLOW  = 3'h6,
        ST_COAST = 3'h7
    } chop_state_e;

    typedef enum logic [2:0] {
        DK_SLOW  = 3'h0,
        DK_BL1   = 3'h1,
        DK_P25   = 3'h2,
        DK_P50   = 3'h3,
        DK_P12   = 3'h4,
        DK_FULL  = 3'h5
    } decay_kind_e;
endpackage

// [verilog/sine_trip_rom.sv]
// Sine code to full-torque trip level lookup with registered output
`timescale 1ns/1ps
module sine_trip_rom (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic [decay_pkg::CODE_W-1:0]  code,
    output logic      [decay_pkg::MV_W-1:0]    mv
);
    import decay_pkg::*;
    logic [MV_W-1:0] look;

    always_comb begin
        case (code)
            5'h1f, 5'h1e: look = TRIP_FULL_MV;
            5'h1d: look = 9'h1ef;
            5'h1c: look = 9'h1ea;
            5'h1b: look = 9'h1e5;
            5'h1a: look = 9'h1e0;
            5'h19: look = 9'h1d6;
            5'h18: look = 9'h1cc;
            5'h17: look = 9'h1c2;
            5'h16: look = 9'h1b8;
            5'h15: look = 9'h1ae;
            5'h14: look = 9'h19f;
            5'h13: look = 9'h190;
            5'h12: look = 9'h181;
            5'h11: look = 9'h172;
            5'h10: look = 9'h163;
            5'h0f: look = 9'h14f;
            5'h0e: look = 9'h13b;
            5'h0d: look = 9'h12c;
            5'h0c: look = 9'h118;
            5'h0b: look = 9'h0ff;
            5'h0a: look = 9'h0eb;
            5'h09: look = 9'h0d7;
            5'h08: look = 9'h0be;
            5'h07: look = 9'h0aa;
            5'h06: look = 9'h091;
            5'h05: look = 9'h078;
            5'h04: look = 9'h064;
            5'h03: look = 9'h04b;
            5'h02: look = 9'h032;
            5'h01: look = 9'h019;
            default: look = 9'h000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mv <= 9'h000;
        end else begin
            mv <= look;
        end
    end
endmodule // sine_trip_rom

// [testbench/bridge_model.sv]
// Behavioural bridge, winding current and current comparator model
`timescale 1ns/1ps
module bridge_model #(
    parameter int TRIP = 40
) (
    input  wire logic pclk,
    input  wire logic gate_hs1,
    input  wire logic gate_ls1,
    input  wire logic gate_hs2,
    input  wire logic gate_ls2,
    output logic      current_sense_node,
    output logic      zero_cross
);
    int amps = 0;

    // Forward drive ramps up, reversed bridge falls fast, others decay slowly
    always @(posedge pclk) begin
        if (gate_hs1 && gate_ls2)
            amps <= amps + 1;
        else if (gate_hs2 && gate_ls1)
            amps <= (amps > 3) ? amps - 3 : 0;
        else if (amps > 0)
            amps <= amps - 1;
    end

    assign current_sense_node = (amps >= TRIP);
    assign zero_cross         = (amps < 3);
endmodule // bridge_model

// [testbench/tb_decay_blank_ctrl.sv]
// Self-checking bench for the chopping decay and blanking controller
`timescale 1ns/1ps
module tb_decay_blank_ctrl;
    import decay_pkg::*;
    localparam logic [1:0] P_LO = 2'h1;
    localparam logic [1:0] P_Z  = 2'h0;
    localparam logic [1:0] P_HI = 2'h2;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, current_sense_node, zero_cross;
    logic gate_hs1, gate_ls1, gate_hs2, gate_ls2, sense_masked;
    logic [CODE_W-1:0] sine_code = 5'h1f;
    logic sleep_request_n = 1, adaptive_decay_pin = 0, current_rising = 0;
    logic [1:0] decay_sel_hi = P_LO, decay_sel_lo = P_LO;
    logic [1:0] off_time_select = P_LO, torque_sel_hi = P_LO;
    logic [1:0] torque_sel_lo = P_LO;
    logic [MV_W-1:0] trip_ref_mv;
    wire  [3:0] g = {gate_hs1, gate_ls1, gate_hs2, gate_ls2};
    int mismatches = 0, num_checks = 0, cyc = 0, n;
    int tc[7] = '{31, 30, 0, 31, 29, 16, 31};
    int te[7] = '{500, 500, 0, 250, 433, 355, 63};
    logic [1:0] th[7] = '{P_LO, P_LO, P_LO, P_Z, P_LO, P_LO, P_HI};
    logic [1:0] tl[7] = '{P_LO, P_LO, P_LO, P_Z, P_Z, P_LO, P_Z};

    decay_blank_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sine_code,
        .current_rising, .phase_pos(1'b1), .sleep_request_n,
        .adaptive_decay_pin, .decay_sel_hi, .decay_sel_lo, .off_time_select,
        .torque_sel_hi, .torque_sel_lo, .current_sense_node, .zero_cross,
        .gate_hs1, .gate_ls1, .gate_hs2, .gate_ls2, .sense_masked,
        .trip_ref_mv);
    bridge_model stage (.pclk, .gate_hs1, .gate_ls1, .gate_hs2, .gate_ls2,
        .current_sense_node, .zero_cross);

    initial begin
        forever #25 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wait_g(input logic [3:0] p, input bit eq, input int lim);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while ((g === p) != eq && n < lim);
    endtask

    // Skip a partial period, check the decay gates, then time the off period and the blanking
    task automatic period(input int blank, input int off,
                          input logic [3:0] dec);
        repeat (10) @(posedge pclk);
        wait_g(4'h9, 1, 1000);
        wait_g(4'h9, 0, 300);
        chk(g, dec);
        wait_g(4'h9, 1, off + 20);
        chk(n, off);
        n = 0;
        while (sense_masked === 1'b1 && n < 100) begin
            @(negedge pclk);
            n++;
        end
        chk(n, blank);
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, ADDR_CTRL, 0);
        chk(rd, CTRL_RESET);
        apb(0, 8'h08, 0);
        chk({rd[30:0], err}, 32'h1);
        apb(1, ADDR_CTRL, 0);
        apb(0, ADDR_STATUS, 0);
        chk({rd[2:0], g}, {ST_SLEEP, 4'h0});
        apb(1, ADDR_CTRL, 1);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            @(posedge pclk);
            sine_code <= CODE_W'(tc[i]);
            torque_sel_hi <= th[i];
            torque_sel_lo <= tl[i];
            repeat (10) @(posedge pclk);
            chk(32'(trip_ref_mv), te[i]);
        end
        sine_code <= 5'h1f;
        torque_sel_hi <= P_LO;
        torque_sel_lo <= P_LO;
        $display("test trip reference done");
        period(36, 400, 4'h5);
        @(posedge pclk);
        decay_sel_hi <= P_HI;
        decay_sel_lo <= P_HI;
        off_time_select <= P_Z;
        sine_code <= 5'h02;
        period(18, 200, 4'h6);
        @(posedge pclk);
        current_rising <= 1;
        period(18, 200, 4'h5);
        @(posedge pclk);
        current_rising <= 0;
        decay_sel_hi <= P_LO;
        decay_sel_lo <= P_LO;
        off_time_select <= P_HI;
        sine_code <= 5'h1f;
        torque_sel_hi <= P_Z;
        torque_sel_lo <= P_Z;
        period(30, 600, 4'h5);
        $display("test decay periods done");
        @(posedge pclk);
        torque_sel_hi <= P_HI;
        torque_sel_lo <= P_HI;
        repeat (10) @(posedge pclk);
        chk(g, 0);
        torque_sel_lo <= P_LO;
        sleep_request_n <= 0;
        adaptive_decay_pin <= 1;
        decay_sel_hi <= P_HI;
        decay_sel_lo <= P_HI;
        repeat (10) @(posedge pclk);
        chk(g, 0);
        sleep_request_n <= 1;
        repeat (10) @(posedge pclk);
        adaptive_decay_pin <= 0;
        apb(0, ADDR_STATUS, 0);
        chk(rd[ST_ADAPT_BIT], 1);
        period(24, 600, 4'h5);
        @(posedge pclk);
        sleep_request_n <= 0;
        repeat (10) @(posedge pclk);
        sleep_request_n <= 1;
        repeat (10) @(posedge pclk);
        apb(0, ADDR_STATUS, 0);
        chk(rd[ST_ADAPT_BIT], 0);
        $display("test sleep and torque off done");
        stop_test();
    end
endmodule // tb_decay_blank_ctrl
